// ===== hw/stlc_pkg.sv
// holds the register map, field layout, reset values and scaling constants
// assumes one clock domain, a simple same-clock register port and 12-bit adc words
package stlc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STLC_OFS_VALUE_FIRST  = 8'h15;
   localparam logic [7:0] STLC_OFS_VALUE_SECOND = 8'h16;
   localparam logic [7:0] STLC_OFS_VALUE_THIRD  = 8'h17;
   localparam logic [7:0] STLC_OFS_LOAD_LINE    = 8'h36;
   localparam logic [7:0] STLC_OFS_TRIM_FIRST   = 8'h38;
   localparam logic [7:0] STLC_OFS_TRIM_SECOND  = 8'h39;
   localparam logic [7:0] STLC_OFS_TRIM_THIRD   = 8'h3A;
   // the upper nibble of each value register sits this far above its low byte
   localparam logic [7:0] STLC_OFS_VALUE_HI_STEP = 8'h40;

   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int STLC_LL_ENABLE_BIT = 3;
   localparam int STLC_LL_CODE_MSB   = 2;
   localparam int STLC_TRIM_SIGN_BIT = 7;
   localparam int STLC_TRIM_MAG_MSB  = 6;
   localparam logic [7:0] STLC_LOAD_LINE_RESET = 8'h00;
   localparam logic [7:0] STLC_TRIM_RESET      = 8'h00;

   // ----------------------------------------------------------------
   // scaling
   // ----------------------------------------------------------------
   localparam int STLC_ADC_W      = 12;
   localparam int STLC_CHANNELS   = 3;
   // one trim lsb is 1/1024 of the reading, so full scale is about +-12.4 %
   localparam int STLC_TRIM_SHIFT = 10;
   localparam int STLC_IMP_W      = 11;
   localparam int STLC_CUR_W      = 8;
   localparam int STLC_DROOP_W    = 11;

   // droop impedance in units of 0.05 milliohm, indexed by the load line code
   localparam logic [10:0] STLC_IMP_CODE0 = 11'h406; // 51.5
   localparam logic [10:0] STLC_IMP_CODE1 = 11'h208; // 26
   localparam logic [10:0] STLC_IMP_CODE2 = 11'h0FA; // 12.5
   localparam logic [10:0] STLC_IMP_CODE3 = 11'h07D; // 6.25
   localparam logic [10:0] STLC_IMP_CODE4 = 11'h03C; // 3
   localparam logic [10:0] STLC_IMP_CODE5 = 11'h01E; // 1.5
   localparam logic [10:0] STLC_IMP_CODE6 = 11'h00E; // 0.7
   localparam logic [10:0] STLC_IMP_CODE7 = 11'h000; // 0

endpackage

// ===== hw/stlc_sense_trim_loadline_config.sv
// holds the load line and sense gain trim register bank with the trim datapath
// assumes register port, adc words and load current come from logic on clk
// assumes the adc strobes one conversion per channel per pulse on adcValid
`timescale 1ns/1ps
module stlc_sense_trim_loadline_config
   import stlc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    reset,
   // register port
   input  wire logic [7:0]              regAddr,
   input  wire logic                    regWrite,
   input  wire logic [7:0]              regWrData,
   input  wire logic                    regRead,
   output logic      [7:0]              regRdData,
   output logic                         regRdValid,
   // adc readings in, trimmed readings out
   input  wire logic [STLC_ADC_W*3-1:0] adcRaw,
   input  wire logic [2:0]              adcValid,
   output logic      [STLC_ADC_W*3-1:0] senseValue,
   output logic      [2:0]              senseUpdated,
   // load line
   input  wire logic [STLC_CUR_W-1:0]   loadCurrent,
   output logic      [STLC_DROOP_W-1:0] droopOffset,
   output logic      [STLC_IMP_W-1:0]   droopImpedance,
   output logic                         droopEnabled
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] loadLineConfig;
   logic [7:0] trimReg [STLC_CHANNELS];
   logic [STLC_ADC_W-1:0] valueReg [STLC_CHANNELS];

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire selLoadLine = (regAddr == STLC_OFS_LOAD_LINE);
   wire [2:0] selTrim = {regAddr == STLC_OFS_TRIM_THIRD,
                         regAddr == STLC_OFS_TRIM_SECOND,
                         regAddr == STLC_OFS_TRIM_FIRST};
   wire [2:0] selValue = {regAddr == STLC_OFS_VALUE_THIRD,
                          regAddr == STLC_OFS_VALUE_SECOND,
                          regAddr == STLC_OFS_VALUE_FIRST};

   // a write lands at its strobe edge, so a read in the next cycle sees it
   wire wrLoadLine = regWrite && selLoadLine;

   // ----------------------------------------------------------------
   // load line register
   // ----------------------------------------------------------------
   // all eight bits stored; bits 7:4 feed nothing else
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loadLineConfig <= STLC_LOAD_LINE_RESET;
      end else if (wrLoadLine) begin
         loadLineConfig <= regWrData;
      end
   end

   // ----------------------------------------------------------------
   // per channel trim and value
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < STLC_CHANNELS; ch++) begin : gChan
         wire [STLC_ADC_W-1:0] raw = adcRaw[ch*STLC_ADC_W +: STLC_ADC_W];
         wire                  wrTrim = regWrite && selTrim[ch];

         // ---------------------------------------------------------
         // trim datapath
         // ---------------------------------------------------------
         // magnitude scales the correction for channels one, two, three
         // a 12 by 7 bit product needs 19 bits, so no term is lost here
         wire [STLC_ADC_W+6:0] product = raw * trimReg[ch][STLC_TRIM_MAG_MSB:0];
         // only bits 18:10 of the product exist; the top of delta is zero
         wire [STLC_ADC_W-1:0] delta   = {3'h0, product[STLC_ADC_W+6:STLC_TRIM_SHIFT]};
         wire                  negTrim = trimReg[ch][STLC_TRIM_SIGN_BIT];
         wire [STLC_ADC_W:0]   sum     = {1'b0, raw} + {1'b0, delta};
         // clamp rather than wrap, so a large trim cannot fold the reading
         wire [STLC_ADC_W-1:0] upGain  = sum[STLC_ADC_W] ? {STLC_ADC_W{1'b1}}
                                                           : sum[STLC_ADC_W-1:0];
         // delta stays below raw, so a negative trim cannot wrap below zero
         wire [STLC_ADC_W-1:0] downGain = raw - delta;
         wire [STLC_ADC_W-1:0] next_value = negTrim ? downGain : upGain;

         // ---------------------------------------------------------
         // trim and value registers
         // ---------------------------------------------------------
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               trimReg[ch] <= STLC_TRIM_RESET;
            end else if (wrTrim) begin
               trimReg[ch] <= regWrData;
            end
         end

         // new trim shows on the next conversion; old value stands until then
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               valueReg[ch] <= '0;
            end else if (adcValid[ch]) begin
               valueReg[ch] <= next_value;
            end
         end

         // one pulse per conversion, so a fresh reading can be told from a stale one
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               senseUpdated[ch] <= 1'b0;
            end else begin
               senseUpdated[ch] <= adcValid[ch];
            end
         end

         assign senseValue[ch*STLC_ADC_W +: STLC_ADC_W] = valueReg[ch];
      end
   endgenerate

   // ----------------------------------------------------------------
   // load line droop
   // ----------------------------------------------------------------
   wire [2:0] llCode = loadLineConfig[STLC_LL_CODE_MSB:0];
   wire       llEnable = loadLineConfig[STLC_LL_ENABLE_BIT];
   // code 0 is the steepest line and code 7 the flat one
   wire [STLC_IMP_W-1:0] impSel =
      (llCode == 3'h0) ? STLC_IMP_CODE0 :
      (llCode == 3'h1) ? STLC_IMP_CODE1 :
      (llCode == 3'h2) ? STLC_IMP_CODE2 :
      (llCode == 3'h3) ? STLC_IMP_CODE3 :
      (llCode == 3'h4) ? STLC_IMP_CODE4 :
      (llCode == 3'h5) ? STLC_IMP_CODE5 :
      (llCode == 3'h6) ? STLC_IMP_CODE6 : STLC_IMP_CODE7;
   // load current is a fraction of full load, 8'hFF being full
   // the widest impedance times full load fits the 19-bit product
   wire [STLC_IMP_W+STLC_CUR_W-1:0] droopProduct = impSel * loadCurrent;
   // a cleared enable forces zero droop whatever the code says
   wire [STLC_DROOP_W-1:0] next_droop = llEnable
      ? droopProduct[STLC_CUR_W +: STLC_DROOP_W] : '0;

   // ----------------------------------------------------------------
   // droop outputs
   // ----------------------------------------------------------------
   // all three follow the register one cycle late; droopOffset also follows load current one cycle late
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         droopOffset <= '0;
      end else begin
         droopOffset <= next_droop;
      end
   end

   // reported even while disabled, so software can check the code it wrote
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         droopImpedance <= '0;
      end else begin
         droopImpedance <= impSel;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         droopEnabled <= 1'b0;
      end else begin
         droopEnabled <= llEnable;
      end
   end

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   // value registers are 12 bits wide; only the low byte fits this 8-bit port,
   // the upper nibble is read at offset plus a fixed step (a high-byte mirror)
   wire [7:0] hiOffsetAddr = regAddr - STLC_OFS_VALUE_HI_STEP;
   wire [2:0] selValueHi = {hiOffsetAddr == STLC_OFS_VALUE_THIRD,
                            hiOffsetAddr == STLC_OFS_VALUE_SECOND,
                            hiOffsetAddr == STLC_OFS_VALUE_FIRST};

   // ----------------------------------------------------------------
   // read data select
   // ----------------------------------------------------------------
   // offsets never overlap, so the chain order sets no real priority;
   // unmapped offsets read as zero
   logic [7:0] next_rdData;

   always_comb begin
      next_rdData = 8'h00;
      if (selLoadLine) begin
         next_rdData = loadLineConfig;
      end else if (selTrim[0]) begin
         next_rdData = trimReg[0];
      end else if (selTrim[1]) begin
         next_rdData = trimReg[1];
      end else if (selTrim[2]) begin
         next_rdData = trimReg[2];
      end else if (selValue[0]) begin
         next_rdData = valueReg[0][7:0];
      end else if (selValue[1]) begin
         next_rdData = valueReg[1][7:0];
      end else if (selValue[2]) begin
         next_rdData = valueReg[2][7:0];
      end else if (selValueHi[0]) begin
         next_rdData = {4'h0, valueReg[0][11:8]};
      end else if (selValueHi[1]) begin
         next_rdData = {4'h0, valueReg[1][11:8]};
      end else if (selValueHi[2]) begin
         next_rdData = {4'h0, valueReg[2][11:8]};
      end
   end

   // one pulse per read strobe, one cycle after it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
      end
   end

   // read data holds the last value read until the next read strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         regRdData <= next_rdData;
      end
   end

endmodule

// ===== testbench/stlc_config_asserts.sv
// checker for the load line and sense trim bank, watching only the top ports
// keeps its own copy of the four registers from the write strobes it sees
`timescale 1ns/1ps
module stlc_config_asserts
   import stlc_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic        regRdValid,
   input wire logic        droopEnabled,
   input wire logic [7:0]  regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic [7:0]  regRdData,
   input wire logic [7:0]  loadCurrent,
   input wire logic [35:0] adcRaw,
   input wire logic [35:0] senseValue,
   input wire logic [2:0]  adcValid,
   input wire logic [2:0]  senseUpdated,
   input wire logic [10:0] droopOffset,
   input wire logic [10:0] droopImpedance
);
   localparam logic [10:0] IMP [8] = '{11'h406, 11'h208, 11'h0FA, 11'h07D,
                                       11'h03C, 11'h01E, 11'h00E, 11'h000};
   logic [7:0] regCopy [4];
   wire        hit = regAddr inside {8'h36, 8'h38, 8'h39, 8'h3A};
   wire  [1:0] idx = (regAddr == 8'h36) ? 2'h3 : regAddr[1:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   always_ff @(posedge clk or posedge reset)
      if (reset) regCopy <= '{default: 8'h00};
      else if (regWrite && hit) regCopy[idx] <= regWrData;
   // positive trim clips at full scale; negative trim can never underflow
   function automatic logic [11:0] trim(logic [11:0] r, logic [7:0] t);
      logic [12:0] d;
      d = 13'((19'(r) * t[6:0]) >> 10);
      return t[7] ? r - d[11:0] : (({1'b0, r} + d) > 13'hFFF ? 12'hFFF : r + d[11:0]);
   endfunction
   property p_droop;
      droopOffset == (droopEnabled ? (19'(droopImpedance) * $past(loadCurrent)) >> 8 : 19'h0);
   endproperty
   a_droop: assert property (p_droop) else $error("droop offset wrong");
   property p_imp;
      !$past(reset) |-> droopImpedance == IMP[$past(regCopy[3][2:0])]
                        && droopEnabled == $past(regCopy[3][3]);
   endproperty
   a_imp: assert property (p_imp) else $error("droop impedance wrong");
   property p_sign; adcValid[0] && regCopy[0][7] |=> senseValue[11:0] <= $past(adcRaw[11:0]);
   endproperty
   a_sign: assert property (p_sign) else $error("negative trim raised reading");
   property p_chan_0;
      adcValid[0] |=> senseValue[11:0] == trim($past(adcRaw[11:0]), $past(regCopy[0]));
   endproperty
   a_chan_0: assert property (p_chan_0) else $error("first reading wrong");
   property p_chan_1;
      adcValid[1] |=> senseValue[23:12] == trim($past(adcRaw[23:12]), $past(regCopy[1]));
   endproperty
   a_chan_1: assert property (p_chan_1) else $error("second reading wrong");
   property p_chan_2;
      adcValid[2] |=> senseValue[35:24] == trim($past(adcRaw[35:24]), $past(regCopy[2]));
   endproperty
   a_chan_2: assert property (p_chan_2) else $error("third reading wrong");
   property p_read; regRead && hit |=> regRdValid && regRdData == $past(regCopy[idx]); endproperty
   a_read: assert property (p_read) else $error("register readback wrong");
   property p_upd; !$past(reset) |-> senseUpdated == $past(adcValid); endproperty
   a_upd: assert property (p_upd) else $error("update strobe wrong");
   cover property (adcValid[0] && regCopy[0][7]);
   cover property (regRead && regAddr == 8'h36);
   cover property (droopEnabled && droopOffset != 11'h000);
endmodule
bind stlc_sense_trim_loadline_config stlc_config_asserts i_chk (
   .clk            (clk),
   .reset          (reset),
   .regWrite       (regWrite),
   .regRead        (regRead),
   .regRdValid     (regRdValid),
   .droopEnabled   (droopEnabled),
   .regAddr        (regAddr),
   .regWrData      (regWrData),
   .regRdData      (regRdData),
   .loadCurrent    (loadCurrent),
   .adcRaw         (adcRaw),
   .senseValue     (senseValue),
   .adcValid       (adcValid),
   .senseUpdated   (senseUpdated),
   .droopOffset    (droopOffset),
   .droopImpedance (droopImpedance)
);

// ===== testbench/stlc_sense_trim_loadline_config_tb.sv
// self-checking bench for the load line and sense trim register bank
// drives the register port and adc strobes itself on falling clock edges
`timescale 1ns/1ps
module stlc_sense_trim_loadline_config_tb
   import stlc_pkg::*;
;
   logic        clk, reset, regWrite, regRead, regRdValid, droopEnabled;
   logic [7:0]  regAddr, regWrData, regRdData, loadCurrent;
   logic [35:0] adcRaw, senseValue;
   logic [2:0]  adcValid, senseUpdated;
   logic [10:0] droopOffset, droopImpedance;
   int          errCount = 0;
   int          numChecks = 0;
   localparam logic [10:0] IMP [8] = '{11'h406, 11'h208, 11'h0FA, 11'h07D,
                                       11'h03C, 11'h01E, 11'h00E, 11'h000};
   // raw, trim, reading: calibration point, negative, clipped, plain positive
   localparam logic [31:0] CASES [4] = '{32'hA2811A53, 32'h400853FB, 32'hFFF7FFFF, 32'hA007FB3D};
   stlc_sense_trim_loadline_config i_dut (
      .clk            (clk),
      .reset          (reset),
      .regAddr        (regAddr),
      .regWrite       (regWrite),
      .regWrData      (regWrData),
      .regRead        (regRead),
      .regRdData      (regRdData),
      .regRdValid     (regRdValid),
      .adcRaw         (adcRaw),
      .adcValid       (adcValid),
      .senseValue     (senseValue),
      .senseUpdated   (senseUpdated),
      .loadCurrent    (loadCurrent),
      .droopOffset    (droopOffset),
      .droopImpedance (droopImpedance),
      .droopEnabled   (droopEnabled)
   );
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string name, logic [11:0] seen, logic [11:0] exp);
      numChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      chk("regRdValid", 12'(regRdValid), 12'h001);
      chk("regRdData", 12'(regRdData), 12'(e));
      @(negedge clk);
   endtask
   task automatic adc(int ch, logic [11:0] raw, logic [11:0] e);
      adcRaw[ch*12 +: 12] = raw;
      adcValid[ch] = 1'b1;
      @(negedge clk);
      adcValid = 3'h0;
      chk("senseUpdated", 12'(senseUpdated[ch]), 12'h001);
      chk("senseValue", senseValue[ch*12 +: 12], e);
   endtask
   initial begin
      reset = 1'b1;
      {regWrite, regRead, regAddr, regWrData, adcRaw, adcValid} = '0;
      loadCurrent = 8'hFF;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      chk("droopImpedance", 12'(droopImpedance), 12'h406);
      for (int i = 0; i < 4; i++) rd(i == 3 ? 8'h36 : 8'h38 + 8'(i), 8'h00);
      for (int c = 0; c < 8; c++) begin
         loadCurrent = 8'(37 * c + 30);
         wr(8'h36, {5'h15, 3'(c)});
         rd(8'h36, {5'h15, 3'(c)});
         chk("droopImpedance", 12'(droopImpedance), 12'(IMP[c]));
         chk("droopEnabled", 12'(droopEnabled), 12'h001);
         chk("droopOffset", 12'(droopOffset), 12'((20'(IMP[c]) * loadCurrent) >> 8));
      end
      wr(8'h36, 8'h05);
      rd(8'h36, 8'h05);
      chk("droopEnabled", 12'(droopEnabled), 12'h000);
      chk("droopOffset", 12'(droopOffset), 12'h000);
      // third channel is trimmed last; the full positive trim 8'h7F is among these cases
      for (int ch = 0; ch < 3; ch++)
         for (int k = 0; k < 4; k++) begin
            wr(8'h38 + 8'(ch), CASES[k][19:12]);
            rd(8'h38 + 8'(ch), CASES[k][19:12]);
            adc(ch, CASES[k][31:20], CASES[k][11:0]);
            rd(8'h15 + 8'(ch), CASES[k][7:0]);
            rd(8'h55 + 8'(ch), {4'h0, CASES[k][11:8]});
         end
      rd(8'h37, 8'h00);
      endSim();
   end
   initial begin
      #200us;
      errCount++;
      endSim();
   end
endmodule
